// ===== ccp_pkg.sv
// Constants and types shared by the CAN command-mode register port
package ccp_pkg;

    // Command frame coding
    localparam logic [10:0] CCP_CMD_ID = 11'h555;
    localparam logic [10:0] CCP_REPLY_ID = 11'h000;
    localparam logic [3:0] CCP_WR_DLC = 4'h3;
    localparam logic [3:0] CCP_RD_DLC = 4'h2;
    localparam logic [3:0] CCP_REPLY_DLC = 4'h1;
    localparam logic [7:0] CCP_OP_WRITE = 8'hf5;
    localparam logic [7:0] CCP_OP_READ = 8'hfd;

    // Register addresses
    localparam logic [7:0] CCP_ADDR_DEV_CTRL = 8'h01;
    localparam logic [7:0] CCP_ADDR_FREQ_SEL = 8'h02;
    localparam logic [7:0] CCP_ADDR_SLEEP_IO = 8'h03;
    localparam logic [7:0] CCP_ADDR_FIFO_THR_LO = 8'h05;
    localparam logic [7:0] CCP_ADDR_FIFO_THR_HI = 8'h06;
    localparam logic [7:0] CCP_ADDR_UNIQUE_ID_BYTE5 = 8'h59;
    localparam logic [7:0] CCP_ADDR_UNIQUE_ID_BYTE4 = 8'h5a;
    localparam logic [7:0] CCP_ADDR_UNIQUE_ID_BYTE3 = 8'h5b;
    localparam logic [7:0] CCP_ADDR_UNIQUE_ID_BYTE2 = 8'h5c;
    localparam logic [7:0] CCP_ADDR_UNIQUE_ID_BYTE1 = 8'h5d;
    localparam logic [7:0] CCP_ADDR_UNIQUE_ID_BYTE0 = 8'h5e;

    // Values after reset
    localparam logic [7:0] CCP_RST_DEV_CTRL = 8'hf8;
    localparam logic [7:0] CCP_RST_FREQ_SEL = 8'h50;
    localparam logic [7:0] CCP_RST_SLEEP_IO = 8'h2c;
    localparam logic [7:0] CCP_RST_FIFO_THR_LO = 8'h00;
    localparam logic [7:0] CCP_RST_FIFO_THR_HI = 8'h01;

    // Writable bits of each register
    localparam logic [7:0] CCP_WMASK_DEV_CTRL = 8'h09;
    localparam logic [7:0] CCP_WMASK_FREQ_SEL = 8'hff;
    localparam logic [7:0] CCP_WMASK_SLEEP_IO = 8'h0f;
    localparam logic [7:0] CCP_WMASK_FIFO_THR_LO = 8'hff;
    localparam logic [7:0] CCP_WMASK_FIFO_THR_HI = 8'h03;

    // Field positions
    localparam int CCP_SLEEP_REQ_BIT = 7;
    localparam int CCP_OVF_BIT = 5;

    // Unique identifier, value arbitrary
    localparam logic [47:0] CCP_UNIQUE_ID_DEFAULT = 48'h0123_4567_89ab;

    // Timing
    localparam int CCP_CLK_PERIOD_PS = 10000;
    localparam int CCP_CMD_SETUP_NS = 100;
    localparam int CCP_CMD_SETUP_CYC =
        ((CCP_CMD_SETUP_NS * 1000) + CCP_CLK_PERIOD_PS - 1) / CCP_CLK_PERIOD_PS;
    localparam int CCP_CNT_W = 8;

    // Received or transmitted CAN frame
    typedef struct packed {
        logic ext;
        logic [10:0] id;
        logic [3:0] dlc;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
    } ccp_frame_t;

    // Configuration register outputs
    typedef struct packed {
        logic [7:0] dev_ctrl;
        logic [7:0] freq_sel;
        logic [7:0] sleep_io;
        logic [7:0] fifo_thr_lo;
        logic [7:0] fifo_thr_hi;
    } ccp_cfg_t;

    typedef enum logic [2:0] {
        CCP_ST_NORMAL = 3'b001,
        CCP_ST_CMD = 3'b010,
        CCP_ST_REPLY = 3'b100
    } ccp_state_t;

endpackage

// ===== ccp_regfile.sv
// Configuration registers and unique identifier with read decode
`timescale 1ns/1ps
`default_nettype none
module ccp_regfile
    import ccp_pkg::*;
#(
    parameter logic [47:0] UNIQUE_ID = CCP_UNIQUE_ID_DEFAULT
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Write port
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read port
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    // Status and configuration
    input wire logic fifo_overflow,
    output ccp_cfg_t cfg,
    output logic sleep_req
);

    ccp_cfg_t cfg_q, cfg_d;
    logic sleep_req_q, sleep_req_d;

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nv,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (nv & mask);
    endfunction

    always_comb
    begin
        cfg_d = cfg_q;
        sleep_req_d = 1'b0;
        if (wr_en)
        begin
            unique case (wr_addr)
                CCP_ADDR_DEV_CTRL: cfg_d.dev_ctrl = merge(cfg_q.dev_ctrl, wr_data,
                                                          CCP_WMASK_DEV_CTRL);
                CCP_ADDR_FREQ_SEL: cfg_d.freq_sel = merge(cfg_q.freq_sel, wr_data,
                                                          CCP_WMASK_FREQ_SEL);
                CCP_ADDR_SLEEP_IO:
                begin
                    cfg_d.sleep_io = merge(cfg_q.sleep_io, wr_data, CCP_WMASK_SLEEP_IO);
                    // Write-only request bit, seen for one cycle then gone
                    sleep_req_d = wr_data[CCP_SLEEP_REQ_BIT];
                end
                CCP_ADDR_FIFO_THR_LO: cfg_d.fifo_thr_lo = merge(cfg_q.fifo_thr_lo, wr_data,
                                                                CCP_WMASK_FIFO_THR_LO);
                CCP_ADDR_FIFO_THR_HI: cfg_d.fifo_thr_hi = merge(cfg_q.fifo_thr_hi, wr_data,
                                                                CCP_WMASK_FIFO_THR_HI);
                // Identifier bytes and unmapped addresses drop the write
                default: cfg_d = cfg_q;
            endcase
        end
    end

    // Values persist until reset only
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_q <= '{CCP_RST_DEV_CTRL, CCP_RST_FREQ_SEL, CCP_RST_SLEEP_IO,
                       CCP_RST_FIFO_THR_LO, CCP_RST_FIFO_THR_HI};
            sleep_req_q <= 1'b0;
        end
        else
        begin
            cfg_q <= cfg_d;
            sleep_req_q <= sleep_req_d;
        end
    end

    always_comb
    begin
        unique case (rd_addr)
            CCP_ADDR_DEV_CTRL: rd_data = cfg_q.dev_ctrl;
            CCP_ADDR_FREQ_SEL: rd_data = cfg_q.freq_sel;
            CCP_ADDR_SLEEP_IO: rd_data = cfg_q.sleep_io;
            CCP_ADDR_FIFO_THR_LO: rd_data = cfg_q.fifo_thr_lo;
            CCP_ADDR_FIFO_THR_HI: rd_data = cfg_q.fifo_thr_hi | (8'h01 << CCP_OVF_BIT)
                                            & {8{fifo_overflow}};
            CCP_ADDR_UNIQUE_ID_BYTE5: rd_data = UNIQUE_ID[47:40];
            CCP_ADDR_UNIQUE_ID_BYTE4: rd_data = UNIQUE_ID[39:32];
            CCP_ADDR_UNIQUE_ID_BYTE3: rd_data = UNIQUE_ID[31:24];
            CCP_ADDR_UNIQUE_ID_BYTE2: rd_data = UNIQUE_ID[23:16];
            CCP_ADDR_UNIQUE_ID_BYTE1: rd_data = UNIQUE_ID[15:8];
            CCP_ADDR_UNIQUE_ID_BYTE0: rd_data = UNIQUE_ID[7:0];
            default: rd_data = 8'h00;
        endcase
    end

    assign cfg = cfg_q;
    assign sleep_req = sleep_req_q;

    property p_uid_msb;
        @(posedge clk) disable iff (!rst_b)
        rd_addr == CCP_ADDR_UNIQUE_ID_BYTE5 |-> rd_data == UNIQUE_ID[47:40];
    endproperty
    a_uid_msb: assert property (p_uid_msb) else $error("Identifier MSB wrong");

    property p_uid_lsb;
        @(posedge clk) disable iff (!rst_b)
        rd_addr == CCP_ADDR_UNIQUE_ID_BYTE0 |-> rd_data == UNIQUE_ID[7:0];
    endproperty
    a_uid_lsb: assert property (p_uid_lsb) else $error("Identifier LSB wrong");

    property p_persist;
        @(posedge clk) disable iff (!rst_b)
        !wr_en |=> $stable(cfg_q);
    endproperty
    a_persist: assert property (p_persist) else $error("Register changed without write");

    property p_freq_write;
        @(posedge clk) disable iff (!rst_b)
        wr_en && wr_addr == CCP_ADDR_FREQ_SEL |=> cfg_q.freq_sel == $past(wr_data);
    endproperty
    a_freq_write: assert property (p_freq_write) else $error("Write not stored");

endmodule // ccp_regfile
`default_nettype wire

// ===== ccp_cmd_port.sv
// Command-mode register access port: frame decode, mode gating and read replies
`timescale 1ns/1ps
`default_nettype none
module ccp_cmd_port
    import ccp_pkg::*;
#(
    parameter logic [47:0] UNIQUE_ID = CCP_UNIQUE_ID_DEFAULT,
    parameter int SETUP_CYC = CCP_CMD_SETUP_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Command select pin
    input wire logic command_select_n,
    // Frames from the CAN controller
    input wire logic rx_valid,
    input wire ccp_frame_t rx_frame,
    // Reply frame to the CAN controller
    input wire logic tx_ready,
    output logic tx_valid,
    output ccp_frame_t tx_frame,
    // Mode controls to the rest of the transceiver
    output logic soft_reset_hold,
    output logic rx_fifo_flush,
    output logic pl_tx_enable,
    output logic pl_rx_deliver,
    // Configuration and status
    input wire logic fifo_overflow,
    output ccp_cfg_t cfg,
    output logic sleep_req
);

    // Counter width bounds the setup time that can be served
    if (SETUP_CYC < 1 || SETUP_CYC >= (1 << CCP_CNT_W))
    begin : g_setup_check
        $error("SETUP_CYC out of range");
    end

    localparam logic [CCP_CNT_W-1:0] SETUP_LAST = CCP_CNT_W'(SETUP_CYC);

    ccp_state_t state_q, state_d;
    logic [CCP_CNT_W-1:0] setup_cnt_q, setup_cnt_d;
    logic tx_valid_q, tx_valid_d;
    ccp_frame_t tx_frame_q, tx_frame_d;
    logic cmd_mode_q, cmd_mode_d;
    logic flush_q, pl_tx_q, pl_rx_q;
    logic setup_done, is_write, is_read, wr_en, read_take;
    logic [7:0] rd_data;

    // Standard frame on the command identifier with the given length and opcode
    function automatic logic cmd_match(input ccp_frame_t f, input logic [3:0] dlc,
                                       input logic [7:0] op);
        cmd_match = !f.ext && f.id == CCP_CMD_ID && f.dlc == dlc && f.b0 == op;
    endfunction

    // Frames before the select setup time are treated as malformed
    assign setup_done = setup_cnt_q == SETUP_LAST;
    assign is_write = cmd_match(rx_frame, CCP_WR_DLC, CCP_OP_WRITE);
    assign is_read = cmd_match(rx_frame, CCP_RD_DLC, CCP_OP_READ);
    assign wr_en = state_q == CCP_ST_CMD && !command_select_n && setup_done
                   && rx_valid && is_write;
    assign read_take = state_q == CCP_ST_CMD && !command_select_n && setup_done
                       && rx_valid && is_read;

    ccp_regfile #(
        .UNIQUE_ID(UNIQUE_ID)
    ) u_regfile (
        .clk(clk),
        .rst_b(rst_b),
        .wr_en(wr_en),
        .wr_addr(rx_frame.b1),
        .wr_data(rx_frame.b2),
        .rd_addr(rx_frame.b1),
        .rd_data(rd_data),
        .fifo_overflow(fifo_overflow),
        .cfg(cfg),
        .sleep_req(sleep_req)
    );

    // Command sequencer
    always_comb
    begin
        state_d = state_q;
        setup_cnt_d = setup_cnt_q;
        tx_valid_d = tx_valid_q;
        tx_frame_d = tx_frame_q;
        unique case (state_q)
            CCP_ST_NORMAL:
            begin
                setup_cnt_d = '0;
                if (!command_select_n)
                    state_d = CCP_ST_CMD;
            end
            CCP_ST_CMD:
            begin
                if (!setup_done)
                    setup_cnt_d = setup_cnt_q + 1'b1;
                if (command_select_n)
                begin
                    state_d = CCP_ST_NORMAL;
                end
                else if (setup_done && rx_valid && is_read)
                begin
                    state_d = CCP_ST_REPLY;
                    tx_valid_d = 1'b1;
                    tx_frame_d = '{1'b0, CCP_REPLY_ID, CCP_REPLY_DLC,
                                   rd_data, 8'h00, 8'h00};
                end
            end
            CCP_ST_REPLY:
            begin
                // Host must wait for the reply; an early release drops it
                if (command_select_n)
                begin
                    state_d = CCP_ST_NORMAL;
                    tx_valid_d = 1'b0;
                end
                else if (tx_ready)
                begin
                    state_d = CCP_ST_CMD;
                    tx_valid_d = 1'b0;
                end
            end
            default:
            begin
                state_d = CCP_ST_NORMAL;
                tx_valid_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= CCP_ST_NORMAL;
            setup_cnt_q <= '0;
            tx_valid_q <= 1'b0;
            tx_frame_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            setup_cnt_q <= setup_cnt_d;
            tx_valid_q <= tx_valid_d;
            tx_frame_q <= tx_frame_d;
        end
    end

    // Mode gating follows the pin directly, one flop deep
    always_comb
    begin
        cmd_mode_d = !command_select_n;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmd_mode_q <= 1'b0;
            flush_q <= 1'b0;
            pl_tx_q <= 1'b1;
            pl_rx_q <= 1'b1;
        end
        else
        begin
            cmd_mode_q <= cmd_mode_d;
            flush_q <= cmd_mode_d;
            pl_tx_q <= !cmd_mode_d;
            pl_rx_q <= !cmd_mode_d;
        end
    end

    assign tx_valid = tx_valid_q;
    assign tx_frame = tx_frame_q;
    assign soft_reset_hold = cmd_mode_q;
    assign rx_fifo_flush = flush_q;
    assign pl_tx_enable = pl_tx_q;
    assign pl_rx_deliver = pl_rx_q;

    sequence s_read_taken;
        read_take;
    endsequence

    sequence s_reply_shown;
        tx_valid && tx_frame.id == CCP_REPLY_ID && tx_frame.dlc == CCP_REPLY_DLC;
    endsequence

    property p_cmd_gating;
        @(posedge clk) disable iff (!rst_b)
        !command_select_n |=> soft_reset_hold && rx_fifo_flush && !pl_tx_enable
                              && !pl_rx_deliver;
    endproperty
    a_cmd_gating: assert property (p_cmd_gating) else $error("Command mode not gated");

    property p_exit;
        @(posedge clk) disable iff (!rst_b)
        command_select_n |=> !soft_reset_hold && pl_tx_enable && pl_rx_deliver
                             && state_q == CCP_ST_NORMAL;
    endproperty
    a_exit: assert property (p_exit) else $error("Normal mode not resumed");

    property p_read_reply;
        logic [7:0] v;
        @(posedge clk) disable iff (!rst_b)
        (s_read_taken, v = rd_data) |=> s_reply_shown ##0 tx_frame.b0 == v;
    endproperty
    a_read_reply: assert property (p_read_reply) else $error("Read reply wrong");

    property p_reply_hold;
        @(posedge clk) disable iff (!rst_b)
        tx_valid && !tx_ready && !command_select_n |=> tx_valid && $stable(tx_frame);
    endproperty
    a_reply_hold: assert property (p_reply_hold) else $error("Reply dropped");

    property p_no_stray_reply;
        @(posedge clk) disable iff (!rst_b)
        !tx_valid && !read_take |=> !tx_valid;
    endproperty
    a_no_stray_reply: assert property (p_no_stray_reply) else $error("Reply without read");

    property p_write_only_valid;
        @(posedge clk) disable iff (!rst_b)
        wr_en |-> !rx_frame.ext && rx_frame.id == CCP_CMD_ID && rx_frame.dlc == CCP_WR_DLC
                  && rx_frame.b0 == CCP_OP_WRITE && !command_select_n;
    endproperty
    a_write_only_valid: assert property (p_write_only_valid) else $error("Bad write taken");

    property p_no_write_normal;
        @(posedge clk) disable iff (!rst_b)
        command_select_n |-> !wr_en;
    endproperty
    a_no_write_normal: assert property (p_no_write_normal) else $error("Write outside mode");

    property p_setup_guard;
        @(posedge clk) disable iff (!rst_b)
        $fell(command_select_n) |-> !wr_en [*8];
    endproperty
    a_setup_guard: assert property (p_setup_guard) else $error("Write before setup");

endmodule // ccp_cmd_port
`default_nettype wire

// ===== ccp_host_model.sv
// Host CAN controller model driving the command-mode register port
`timescale 1ns/1ps
`default_nettype none
module ccp_host
    import ccp_pkg::*;
(
    // Clock
    input wire logic clk,
    // Command select and frames towards the port
    output logic command_select_n,
    output logic rx_valid,
    output ccp_frame_t rx_frame,
    // Reply from the port
    output logic tx_ready,
    input wire logic tx_valid,
    input wire ccp_frame_t tx_frame
);
    initial
    begin
        command_select_n = 1'b1;
        rx_valid = 1'b0;
        rx_frame = '0;
        tx_ready = 1'b0;
    end

    // Select low, then hold off frames past the setup time, with margin
    task automatic enter();
        @(negedge clk);
        command_select_n = 1'b0;
        repeat (CCP_CMD_SETUP_CYC + 3) @(negedge clk);
    endtask

    // Select low, then a frame one cycle later, inside the setup time
    task automatic enter_early(input ccp_frame_t f);
        @(negedge clk);
        command_select_n = 1'b0;
        send(f);
    endtask

    // Keep select low past the hold time before release
    task automatic leave();
        repeat (CCP_CMD_SETUP_CYC + 1) @(negedge clk);
        command_select_n = 1'b1;
        @(negedge clk);
    endtask

    // One frame per pulse; the bus shows garbage once released
    task automatic send(input ccp_frame_t f);
        @(negedge clk);
        rx_frame = f;
        rx_valid = 1'b1;
        @(negedge clk);
        rx_valid = 1'b0;
        rx_frame = ~f;
    endtask

    // Wait for the reply, stall a while, then take it at the ready edge
    task automatic get_reply(input int stall, output ccp_frame_t f, output logic got);
        int n;
        n = 0;
        while (tx_valid !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        repeat (stall) @(negedge clk);
        // Reply is registered, so it stands unchanged through the taking edge
        got = tx_valid;
        f = tx_frame;
        tx_ready = 1'b1;
        @(posedge clk);
        @(negedge clk);
        tx_ready = 1'b0;
    endtask
endmodule // ccp_host
`default_nettype wire

// ===== ccp_tb.sv
// Self-checking testbench for the command-mode register port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ccp_pkg::*;
    // Identifier value arbitrary
    localparam logic [47:0] UID = 48'h3c5a_96e1_7b24;
    localparam ccp_cfg_t CFG_RST = {CCP_RST_DEV_CTRL, CCP_RST_FREQ_SEL, CCP_RST_SLEEP_IO,
        CCP_RST_FIFO_THR_LO, CCP_RST_FIFO_THR_HI};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic fifo_overflow = 1'b0;
    logic command_select_n, rx_valid, tx_ready, tx_valid;
    logic soft_reset_hold, rx_fifo_flush, pl_tx_enable, pl_rx_deliver, sleep_req;
    ccp_frame_t rx_frame, tx_frame;
    ccp_cfg_t cfg, exp_cfg;
    int n_fail = 0;
    int checks = 0;

    always #5 clk = ~clk;

    ccp_host h (.clk(clk), .command_select_n(command_select_n), .rx_valid(rx_valid),
        .rx_frame(rx_frame), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_frame(tx_frame));

    ccp_cmd_port #(.UNIQUE_ID(UID)) i_dut (.clk(clk), .rst_b(rst_b),
        .command_select_n(command_select_n), .rx_valid(rx_valid), .rx_frame(rx_frame),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_frame(tx_frame),
        .soft_reset_hold(soft_reset_hold), .rx_fifo_flush(rx_fifo_flush),
        .pl_tx_enable(pl_tx_enable), .pl_rx_deliver(pl_rx_deliver),
        .fifo_overflow(fifo_overflow), .cfg(cfg), .sleep_req(sleep_req));

    task automatic chk_1(input string n, input logic e, input logic g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk_cfg(input string n, input ccp_cfg_t e, input ccp_cfg_t g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_frame(input string n, input ccp_frame_t e, input ccp_frame_t g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // Mode outputs as a group: command mode or normal
    task automatic chk_gates(input logic cmd);
        chk_1("soft_reset_hold", cmd, soft_reset_hold);
        chk_1("rx_fifo_flush", cmd, rx_fifo_flush);
        chk_1("pl_tx_enable", !cmd, pl_tx_enable);
        chk_1("pl_rx_deliver", !cmd, pl_rx_deliver);
    endtask

    task automatic do_write(input logic [7:0] a, input logic [7:0] d);
        h.send({1'b0, CCP_CMD_ID, CCP_WR_DLC, CCP_OP_WRITE, a, d});
    endtask

    task automatic do_read(input logic [7:0] a, input logic [7:0] e, input int stall);
        ccp_frame_t f;
        logic got;
        h.send({1'b0, CCP_CMD_ID, CCP_RD_DLC, CCP_OP_READ, a, 8'h00});
        h.get_reply(stall, f, got);
        chk_1("reply present", 1'b1, got);
        chk_frame("reply frame", {1'b0, CCP_REPLY_ID, CCP_REPLY_DLC, e, 16'h0000}, f);
    endtask

    // No reply may appear for a few cycles after an ignored frame
    task automatic quiet();
        logic seen;
        seen = 1'b0;
        repeat (6)
        begin
            @(negedge clk);
            seen = seen | (tx_valid !== 1'b0);
        end
        chk_1("no reply", 1'b0, seen);
    endtask

    task automatic t_mode();
        chk_cfg("cfg after reset", CFG_RST, cfg);
        chk_gates(1'b0);
        h.enter();
        chk_gates(1'b1);
        h.leave();
        chk_gates(1'b0);
    endtask

    task automatic t_write();
        h.enter();
        do_write(CCP_ADDR_FREQ_SEL, 8'h34);
        do_write(CCP_ADDR_DEV_CTRL, 8'hff);
        @(negedge clk);
        exp_cfg = CFG_RST;
        exp_cfg.freq_sel = 8'h34;
        exp_cfg.dev_ctrl = CCP_RST_DEV_CTRL | CCP_WMASK_DEV_CTRL;
        chk_cfg("cfg after writes", exp_cfg, cfg);
        do_read(CCP_ADDR_FREQ_SEL, 8'h34, 0);
        do_read(CCP_ADDR_FREQ_SEL, 8'h34, 4);
        h.leave();
        chk_cfg("cfg after release", exp_cfg, cfg);
    endtask

    task automatic t_ignore();
        ccp_frame_t bad [6];
        bad[0] = {1'b1, CCP_CMD_ID, CCP_WR_DLC, CCP_OP_WRITE, CCP_ADDR_FREQ_SEL, 8'h11};
        bad[1] = {1'b0, 11'h554, CCP_WR_DLC, CCP_OP_WRITE, CCP_ADDR_FREQ_SEL, 8'h11};
        bad[2] = {1'b0, CCP_CMD_ID, 4'h4, CCP_OP_WRITE, CCP_ADDR_FREQ_SEL, 8'h11};
        bad[3] = {1'b0, CCP_CMD_ID, CCP_WR_DLC, 8'hf4, CCP_ADDR_FREQ_SEL, 8'h11};
        bad[4] = {1'b0, CCP_CMD_ID, CCP_WR_DLC, CCP_OP_WRITE, CCP_ADDR_UNIQUE_ID_BYTE5, 8'h11};
        bad[5] = {1'b0, CCP_CMD_ID, CCP_WR_DLC, CCP_OP_READ, CCP_ADDR_FREQ_SEL, 8'h00};
        h.enter();
        foreach (bad[i])
        begin
            h.send(bad[i]);
            quiet();
        end
        chk_cfg("cfg after ignored", exp_cfg, cfg);
        do_read(CCP_ADDR_UNIQUE_ID_BYTE5, UID[47:40], 1);
        h.leave();
    endtask

    task automatic t_uid();
        h.enter();
        for (int i = 0; i < 6; i++)
        begin
            do_read(CCP_ADDR_UNIQUE_ID_BYTE5 + 8'(i), UID[47 - 8 * i -: 8], i);
        end
        h.leave();
    endtask

    // Early frame, sleep request pulse, overflow status and masked registers
    task automatic t_regs();
        h.enter_early({1'b0, CCP_CMD_ID, CCP_WR_DLC, CCP_OP_WRITE, CCP_ADDR_FREQ_SEL, 8'h77});
        chk_cfg("cfg after early frame", exp_cfg, cfg);
        h.enter();
        do_write(CCP_ADDR_SLEEP_IO, 8'h8a);
        chk_1("sleep_req pulse", 1'b1, sleep_req);
        @(negedge clk);
        chk_1("sleep_req end", 1'b0, sleep_req);
        exp_cfg.sleep_io = (CCP_RST_SLEEP_IO & ~CCP_WMASK_SLEEP_IO) | (8'h8a & CCP_WMASK_SLEEP_IO);
        do_read(CCP_ADDR_SLEEP_IO, exp_cfg.sleep_io, 0);
        do_write(CCP_ADDR_FIFO_THR_HI, 8'hff);
        exp_cfg.fifo_thr_hi = (CCP_RST_FIFO_THR_HI & ~CCP_WMASK_FIFO_THR_HI) | CCP_WMASK_FIFO_THR_HI;
        fifo_overflow = 1'b1;
        do_read(CCP_ADDR_FIFO_THR_HI, exp_cfg.fifo_thr_hi | 8'h20, 2);
        fifo_overflow = 1'b0;
        chk_cfg("cfg after masked writes", exp_cfg, cfg);
        h.leave();
    endtask

    // Reset in mid-run brings every register back to its default
    task automatic t_persist();
        @(negedge clk);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        chk_cfg("cfg after second reset", CFG_RST, cfg);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Whole run is a few hundred cycles; this limit leaves a wide margin
    initial
    begin
        #200000;
        n_fail++;
        results();
    end

    initial
    begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        t_mode();
        t_write();
        t_ignore();
        t_uid();
        t_regs();
        t_persist();
        results();
    end
endmodule // testbench
`default_nettype wire
